// *** sim/temp_monitor_result_status_config_tb.sv ***
/* Self-checking bench of the monitor register block with a converter model.
   Assumes a short period parameter so rate code 8 gives 16 cycles. */
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_result_status_config_tb;
   import tmr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic addr_read_i = 1'b0;
   logic [7:0] rdata_o;
   tmr_conv_s conv_i = '0;
   logic conv_start_o;
   logic conv_chan_o;
   tmr_lim_s [1:0] lim_i;
   logic [11:0] hyst_i = 12'h020;
   logic [1:0] chan_en_i = 2'b11;
   logic open_i = 1'b0;
   tmr_od_s event_pin_o;
   tmr_od_s overtemp_pin_o;
   tmr_acc_s acc;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int seed = 32'he43f;
   int wait_n = 0;
   int n_start = 0;
   int res_q [2];
   int old;
   logic [12:0] t_in [2] = '{13'h0, 13'h0};
   logic [7:0] d;
   logic [7:0] rp [7] = '{8'h00, 8'h01, 8'h10, 8'h15, 8'h03, 8'h04, 8'h30};
   logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};

   always #50 clk_i = ~clk_i;

   tmr_monitor #(.SLOW_PERIOD_CYC(4096)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .acc_i(acc), .addr_read_i(addr_read_i), .rdata_o(rdata_o), .conv_i(conv_i),
      .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .lim_i(lim_i),
      .hyst_i(hyst_i), .chan_en_i(chan_en_i), .open_i(open_i),
      .event_pin_o(event_pin_o), .overtemp_pin_o(overtemp_pin_o));
   tmr_host host (.clk_i(clk_i), .rdata_i(rdata_o), .acc_o(acc));

   // ----------------------------------------
   // Converter model, four cycles per channel
   // ----------------------------------------
   always @(posedge clk_i)
   begin
      conv_i.done <= (wait_n == 1);
      if (conv_start_o)
      begin
         wait_n <= 4;
         n_start <= n_start + 1;
      end
      else if (wait_n > 0)
         wait_n <= wait_n - 1;
      if (wait_n == 1)
      begin
         conv_i.temp <= t_in[conv_chan_o];
         res_q[conv_chan_o] <= int'(t_in[conv_chan_o]);
      end
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic rc(input logic [7:0] p, input logic [7:0] e);
      host.rd(p, d);
      chk($sformatf("reg %h", p), e, d);
   endtask
   // Two remote completions guarantee a whole sequence saw the new inputs
   task automatic wseq();
      for (int n = 0; n < 2; n++)
         for (int i = 0; i < 200; i++)
         begin
            @(negedge clk_i);
            if (conv_i.done === 1'b1 && conv_chan_o === 1'b1)
               break;
         end
      repeat (4) @(negedge clk_i);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      lim_i[0] = '{high: 12'h7ff, low: 12'h800, crit: 12'h7ff};
      lim_i[1] = '{high: 12'h7ff, low: 12'h800, crit: 12'h7ff};
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 7; i++)
         rc(rp[i], rv[i]);
      host.wr(8'h09, 8'ha4);
      rc(8'h03, 8'ha4);
      host.wr(8'h09, 8'h00);
      host.wr(8'h0a, 8'h07);
      rc(8'h04, 8'h07);
      host.wr(8'h0a, 8'h08);
      for (int k = 0; k < 4; k++)
      begin
         t_in[0] = 13'($random(seed) & 32'h7ff);
         t_in[1] = 13'($random(seed) & 32'h7ff);
         wseq();
         rc(8'h00, 8'(res_q[0] >> 4));
         rc(8'h15, 8'(res_q[0] << 4));
         rc(8'h01, 8'(res_q[1] >> 4));
         rc(8'h10, 8'(res_q[1] << 4));
      end
      old = res_q[0];
      host.rd(8'h00, d);
      t_in[0] = t_in[0] ^ 13'h00f;
      wseq();
      rc(8'h15, 8'(old << 4));
      @(posedge clk_i);
      lim_i[0] <= '{high: 12'h100, low: 12'h800, crit: 12'h100};
      t_in[0] = 13'h200;
      wseq();
      chk("overtemp", 8'h00, {7'h0, overtemp_pin_o.oe_n});
      chk("event", 8'h00, {7'h0, event_pin_o.oe_n});
      host.rd(8'h02, d);
      chk("status", 8'h41, d & 8'h7f);
      host.wr(8'h09, 8'h80);
      repeat (3) @(negedge clk_i);
      chk("suppressed", 8'h01, {7'h0, event_pin_o.oe_n});
      host.wr(8'h09, 8'h00);
      t_in[0] = 13'h0f0;
      wseq();
      chk("hysteresis", 8'h00, {7'h0, overtemp_pin_o.oe_n});
      t_in[0] = 13'h0e0;
      wseq();
      chk("released", 8'h01, {7'h0, overtemp_pin_o.oe_n});
      host.rd(8'h02, d);
      chk("held flag", 8'h40, d & 8'h7f);
      host.rd(8'h02, d);
      chk("cleared", 8'h00, d & 8'h7f);
      chk("latch kept", 8'h00, {7'h0, event_pin_o.oe_n});
      @(posedge clk_i);
      addr_read_i <= 1'b1;
      @(posedge clk_i);
      addr_read_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("latch freed", 8'h01, {7'h0, event_pin_o.oe_n});
      // Open sensor: latched flag and event pin; the next status read clears the flag only
      @(posedge clk_i);
      open_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      open_i <= 1'b0;
      repeat (4) @(negedge clk_i);
      chk("open event", 8'h00, {7'h0, event_pin_o.oe_n});
      host.rd(8'h02, d);
      chk("open held", 8'h04, d & 8'h7f);
      host.rd(8'h02, d);
      chk("open cleared", 8'h00, d & 8'h7f);
      // Alternate pin follows the high limit and releases with hysteresis
      host.wr(8'h09, 8'h20);
      t_in[0] = 13'h200;
      wseq();
      chk("alt set", 8'h00, {7'h0, event_pin_o.oe_n});
      t_in[0] = 13'h0e0;
      wseq();
      chk("alt free", 8'h01, {7'h0, event_pin_o.oe_n});
      // Shutdown: no starts until the one-shot, which runs one sequence
      host.wr(8'h09, 8'h40);
      repeat (20) @(negedge clk_i);
      t_in[0] = 13'h153;
      old = n_start;
      repeat (40) @(negedge clk_i);
      chk("idle starts", 8'h00, 8'(n_start - old));
      host.wr(8'h0f, 8'($random(seed)));
      repeat (60) @(negedge clk_i);
      chk("one-shot starts", 8'h02, 8'(n_start - old));
      rc(8'h00, 8'h15);
      rc(8'h15, 8'h30);
      // Extended range: temperature plus 64 degrees, here -255 sixteenths
      host.wr(8'h09, 8'h04);
      t_in[0] = 13'h1f01;
      wseq();
      rc(8'h00, 8'((1024 - 255) >> 4));
      rc(8'h15, 8'((1024 - 255) << 4));
      end_of_test();
   end
endmodule // temp_monitor_result_status_config_tb
`default_nettype wire

// *** sim/tmr_host.sv ***
/* Host controller model: register reads and writes as one-cycle strobes.
   Assumes the block takes a strobe on the rising edge of clk_i. */
`timescale 1ns/1ps
`default_nettype none
module tmr_host (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output tmr_pkg::tmr_acc_s acc_o
);
   import tmr_pkg::*;
   initial acc_o = '0;
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      @(posedge clk_i);
      acc_o <= '{rd: 1'b1, wr: 1'b0, ptr: p, wdata: 8'h00};
      @(posedge clk_i);
      acc_o.rd <= 1'b0;
      @(negedge clk_i);
      d = rdata_i;
   endtask
   // Reserved configuration bits are always sent as zero by the callers
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      @(posedge clk_i);
      acc_o <= '{rd: 1'b0, wr: 1'b1, ptr: p, wdata: v};
      @(posedge clk_i);
      acc_o.wr <= 1'b0;
   endtask
endmodule // tmr_host
`default_nettype wire

// *** src/tmr_monitor.sv ***
/*
 * Register side of a local and remote temperature monitor: results, status,
 * configuration, conversion rate, sequencing and the two open-drain pins.
 * Assumes a serial engine that decodes pointer reads and writes into one-cycle
 * strobes, and a converter that answers each start with a done pulse.
 */
// Operation
// - Local result: upper byte at 00h, fraction nibble high in byte 15h.
// - Remote result: upper byte at 01h, fraction nibble at 10h, low nibble zero.
// - Result bytes are read-only and refreshed at each finished conversion.
// - Reading one byte of a pair locks the other until it or any other register is read.
// - All result bytes are zero after power-on reset.
// - Status byte at 02h is read-only with the fixed flag layout.
// - Status bit 7 shows a conversion in progress.
// - Over flag sets above high limit; under flag only in event mode.
// - Event mode latches over, under, open; alternate mode latches only open.
// - In event mode any latched flag sets the event latch, pin low.
// - Status read clears a latched flag only when its cause is gone.
// - Event latch clears on address read, only with flags and causes clear.
// - Critical flags follow results; overtemp pin low while either set.
// - Critical release at or below limit minus hysteresis.
// - Alternate mode: pin follows high limits, releases with hysteresis.
// - Configuration written at 09h, read at 03h, reset 00h.
// - Suppress bit holds event pin inactive, only in event mode.
// - Shutdown stops after current sequence; clearing it resumes conversions.
// - Range bit selects standard or extended span and format.
// - Rate at 04h read, 0Ah write, reset 08h, idle time only.
// - Rate code n up to 9 gives period of 16 seconds halved n times.
// - While shut down, a write to 0Fh runs one sequence.
`timescale 1ns/1ps
`default_nettype none

module tmr_monitor #(
   parameter int unsigned SLOW_PERIOD_CYC = tmr_pkg::SLOW_PERIOD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire tmr_pkg::tmr_acc_s acc_i,
   input wire logic addr_read_i,
   output logic [7:0] rdata_o,
   input wire tmr_pkg::tmr_conv_s conv_i,
   output logic conv_start_o,
   output logic conv_chan_o,
   input wire tmr_pkg::tmr_lim_s [1:0] lim_i,
   input wire logic [11:0] hyst_i,
   input wire logic [1:0] chan_en_i,
   input wire logic open_i,
   output tmr_pkg::tmr_od_s event_pin_o,
   output tmr_pkg::tmr_od_s overtemp_pin_o
);
   import tmr_pkg::*;

   // ------------------------------------------------------------
   // Number formats
   // ------------------------------------------------------------
   function automatic logic [11:0] enc(input logic [12:0] t, input logic ext);
      logic signed [13:0] v;
      v = {t[12], t};
      if (ext)
      begin
         v = v + EXT_OFFSET;
         if (v < 14'sd0)
            v = 14'sd0;
         else if (v > EXT_MAX)
            v = EXT_MAX;
      end
      else
      begin
         if (v < STD_MIN)
            v = STD_MIN;
         else if (v > STD_MAX)
            v = STD_MAX;
      end
      return v[11:0];
   endfunction

   // Limits share the result format, so both go through the same widening
   function automatic logic signed [13:0] cv(input logic [11:0] x, input logic ext);
      return ext ? $signed({2'b00, x}) : $signed({{2{x[11]}}, x});
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] cfg_r;
   logic [3:0] rate_r;
   logic [7:0] rdata_r;
   tmr_seq_e seq_r, seq_nxt;
   logic ch_r, ch_nxt;
   logic start_r, start_nxt;
   logic oneshot_r;
   logic [31:0] timer_r;
   logic open_m_r, open_s_r;
   logic open_r, alert_r;
   tmr_od_s ev_pin_r, ot_pin_r;

   logic rd, wr, stat_rd, ext, pfs, sdn;
   logic [1:0] over_f, under_f, crit_f, gth, ltl;
   logic [1:0] upd;
   logic [7:0] hi_b [2];
   logic [7:0] lo_b [2];
   logic [11:0] val_w;
   logic any5, cause5, alert_set, alert_clr;
   logic ev_drive, ot_drive;
   logic [3:0] rate_eff;
   logic [31:0] period_w;
   logic go, conv_done, last_ch;
   logic [7:0] status_w, rd_mux;

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   assign rd = acc_i.rd;
   assign wr = acc_i.wr;
   assign stat_rd = rd && (acc_i.ptr == PTR_STATUS);
   assign ext = cfg_r[CFG_RANGE];
   assign pfs = cfg_r[CFG_PIN_FUNC];
   assign sdn = cfg_r[CFG_SHUTDOWN];
   assign val_w = enc(conv_i.temp, ext);

   // ------------------------------------------------------------
   // Per-channel results and flags
   // ------------------------------------------------------------
   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      localparam logic [7:0] P_HI = (i == CH_LOC) ? PTR_LOC_HI : PTR_REM_HI;
      localparam logic [7:0] P_LO = (i == CH_LOC) ? PTR_LOC_LO : PTR_REM_LO;
      logic [11:0] res_r;
      logic over_r, under_r, crit_r;
      logic rd_hi, rd_lo, rd_oth;
      logic signed [13:0] rv, hv, lv, kv, hy;
      logic gt_crit, rel_crit, rel_high;

      assign upd[i] = conv_done && (ch_r == i[0]);
      assign rd_hi = rd && (acc_i.ptr == P_HI);
      assign rd_lo = rd && (acc_i.ptr == P_LO);
      assign rd_oth = rd && !rd_hi && !rd_lo;

      tmr_result_pair u_pair (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .upd_i(upd[i]),
         .val_i(val_w),
         .rd_hi_i(rd_hi),
         .rd_lo_i(rd_lo),
         .rd_other_i(rd_oth),
         .hi_o(hi_b[i]),
         .lo_o(lo_b[i])
      );

      assign rv = cv(res_r, ext);
      assign hv = cv(lim_i[i].high, ext);
      assign lv = cv(lim_i[i].low, ext);
      assign kv = cv(lim_i[i].crit, ext);
      assign hy = $signed({2'b00, hyst_i});
      assign gth[i] = rv > hv;
      assign ltl[i] = rv < lv;
      assign gt_crit = rv > kv;
      assign rel_crit = rv <= (kv - hy);
      assign rel_high = rv <= (hv - hy);

      // Comparison runs on a private copy; the readable bytes may be locked
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
         if (!rst_n_i)
            res_r <= 12'h000;
         else if (upd[i])
            res_r <= val_w;
      end

      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
         if (!rst_n_i)
         begin
            over_r <= 1'b0;
            under_r <= 1'b0;
            crit_r <= 1'b0;
         end
         else
         begin
            if (gth[i])
               over_r <= 1'b1;
            else if (pfs ? rel_high : stat_rd)
               over_r <= 1'b0;
            if (ltl[i] && !pfs)
               under_r <= 1'b1;
            else if (stat_rd || pfs)
               under_r <= 1'b0;
            if (gt_crit)
               crit_r <= 1'b1;
            else if (rel_crit)
               crit_r <= 1'b0;
         end
      end

      assign over_f[i] = over_r;
      assign under_f[i] = under_r;
      assign crit_f[i] = crit_r;
   end

   // ------------------------------------------------------------
   // Open sensor flag and event latch
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         open_m_r <= 1'b0;
         open_s_r <= 1'b0;
      end
      else
      begin
         open_m_r <= open_i;
         open_s_r <= open_m_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         open_r <= 1'b0;
      else if (open_s_r)
         open_r <= 1'b1;
      else if (stat_rd)
         open_r <= 1'b0;
   end

   assign any5 = |{over_f, under_f, open_r};
   assign cause5 = |{gth, ltl, open_s_r};
   assign alert_set = !pfs && any5;
   assign alert_clr = pfs || (addr_read_i && !any5 && !cause5);

   // A new event in the clearing cycle keeps the latch set
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         alert_r <= 1'b0;
      else if (alert_set)
         alert_r <= 1'b1;
      else if (alert_clr)
         alert_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   assign ev_drive = pfs ? |over_f : (alert_r && !cfg_r[CFG_SUPPRESS]);
   assign ot_drive = |crit_f;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ev_pin_r <= '{o: 1'b0, oe_n: 1'b1};
         ot_pin_r <= '{o: 1'b0, oe_n: 1'b1};
      end
      else
      begin
         ev_pin_r <= '{o: 1'b0, oe_n: !ev_drive};
         ot_pin_r <= '{o: 1'b0, oe_n: !ot_drive};
      end
   end

   assign event_pin_o = ev_pin_r;
   assign overtemp_pin_o = ot_pin_r;

   // ------------------------------------------------------------
   // Configuration and rate registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_r <= CFG_RST;
         rate_r <= RATE_RST;
      end
      else if (wr)
      begin
         if (acc_i.ptr == PTR_CFG_WR)
            cfg_r <= acc_i.wdata & CFG_MASK;
         if (acc_i.ptr == PTR_RATE_WR)
            rate_r <= acc_i.wdata[3:0];
      end
   end

   // ------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------
   // Codes above the table run at the fastest listed rate
   assign rate_eff = (rate_r > RATE_MAX) ? RATE_MAX : rate_r;
   assign period_w = 32'(SLOW_PERIOD_CYC) >> rate_eff;
   assign conv_done = (seq_r == SEQ_CONV) && conv_i.done;
   assign last_ch = ch_r || !chan_en_i[CH_REM];
   assign go = (seq_r == SEQ_IDLE) && (|chan_en_i)
      && (sdn ? oneshot_r : (timer_r >= period_w - 32'd1));

   always_comb
   begin
      seq_nxt = seq_r;
      ch_nxt = ch_r;
      start_nxt = 1'b0;
      case (seq_r)
         SEQ_IDLE:
         begin
            if (go)
            begin
               seq_nxt = SEQ_CONV;
               ch_nxt = chan_en_i[CH_LOC] ? 1'b0 : 1'b1;
               start_nxt = 1'b1;
            end
         end
         SEQ_CONV:
         begin
            if (conv_done)
            begin
               if (last_ch)
                  seq_nxt = SEQ_IDLE;
               else
               begin
                  ch_nxt = 1'b1;
                  start_nxt = 1'b1;
               end
            end
         end
         default:
         begin
            seq_nxt = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         seq_r <= SEQ_IDLE;
         ch_r <= 1'b0;
         start_r <= 1'b0;
      end
      else
      begin
         seq_r <= seq_nxt;
         ch_r <= ch_nxt;
         start_r <= start_nxt;
      end
   end

   // Timer runs from each sequence start, so rate never stretches a conversion
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         timer_r <= 32'h0000_0000;
      else if (go)
         timer_r <= 32'h0000_0000;
      else if (timer_r != 32'hffff_ffff)
         timer_r <= timer_r + 32'd1;
   end

   // Written data is dropped; only the strobe matters
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         oneshot_r <= 1'b0;
      else if (wr && sdn && (acc_i.ptr == PTR_ONESHOT))
         oneshot_r <= 1'b1;
      else if (go || !sdn)
         oneshot_r <= 1'b0;
   end

   assign conv_start_o = start_r;
   assign conv_chan_o = ch_r;

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   assign status_w = {seq_r == SEQ_CONV, over_f[CH_LOC], under_f[CH_LOC],
      over_f[CH_REM], under_f[CH_REM], open_r, crit_f[CH_REM], crit_f[CH_LOC]};
   assign rd_mux =
      (acc_i.ptr == PTR_LOC_HI) ? hi_b[CH_LOC] :
      (acc_i.ptr == PTR_REM_HI) ? hi_b[CH_REM] :
      (acc_i.ptr == PTR_LOC_LO) ? lo_b[CH_LOC] :
      (acc_i.ptr == PTR_REM_LO) ? lo_b[CH_REM] :
      (acc_i.ptr == PTR_STATUS) ? status_w :
      (acc_i.ptr == PTR_CFG_RD) ? cfg_r :
      (acc_i.ptr == PTR_RATE_RD) ? {4'h0, rate_r} : 8'h00;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_r <= 8'h00;
      else if (rd)
         rdata_r <= rd_mux;
   end

   assign rdata_o = rdata_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   status_busy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      stat_rd |=> rdata_o[7] == $past(seq_r == SEQ_CONV))
      else $error("status busy bit wrong");

   open_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (open_r && !stat_rd) |=> open_r)
      else $error("open flag dropped without status read");

   latch_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!pfs && any5) |=> alert_r)
      else $error("event latch not set");

   event_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (alert_r && !pfs && !cfg_r[CFG_SUPPRESS]) |=> event_pin_o.oe_n == 1'b0)
      else $error("event pin not driven");

   alt_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pfs && (|over_f)) |=> event_pin_o.oe_n == 1'b0)
      else $error("alternate pin not driven");

   latch_no_stat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (alert_r && stat_rd && !addr_read_i && !pfs) |=> alert_r)
      else $error("event latch cleared by status read");

   crit_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (|crit_f) |=> overtemp_pin_o.oe_n == 1'b0)
      else $error("overtemp pin not driven");

   suppress_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (cfg_r[CFG_SUPPRESS] && !pfs) |=> event_pin_o.oe_n)
      else $error("suppressed event pin driven");

   cfg_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr && acc_i.ptr == PTR_CFG_WR) |=> cfg_r == ($past(acc_i.wdata) & CFG_MASK))
      else $error("configuration write lost");

   rate_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr && acc_i.ptr == PTR_RATE_WR) |=> rate_r == $past(acc_i.wdata[3:0]))
      else $error("rate write lost");

   oneshot_go_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr && sdn && acc_i.ptr == PTR_ONESHOT && seq_r == SEQ_IDLE && (|chan_en_i))
      ##1 sdn |=> conv_start_o)
      else $error("one-shot did not start");

   shutdown_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (sdn && seq_r == SEQ_IDLE && !oneshot_r) |=> !conv_start_o)
      else $error("conversion started in shutdown");

endmodule // tmr_monitor

`default_nettype wire

// *** src/tmr_pkg.sv ***
/*
 * Shared constants and types of the temperature monitor register block.
 * Assumes a 10 MHz core clock and a converter that reports signed sixteenths of a degree.
 */
package tmr_pkg;

   // ------------------------------------------------------------
   // Register pointers
   // ------------------------------------------------------------
   localparam logic [7:0] PTR_LOC_HI = 8'h00;
   localparam logic [7:0] PTR_REM_HI = 8'h01;
   localparam logic [7:0] PTR_STATUS = 8'h02;
   localparam logic [7:0] PTR_CFG_RD = 8'h03;
   localparam logic [7:0] PTR_RATE_RD = 8'h04;
   localparam logic [7:0] PTR_CFG_WR = 8'h09;
   localparam logic [7:0] PTR_RATE_WR = 8'h0a;
   localparam logic [7:0] PTR_ONESHOT = 8'h0f;
   localparam logic [7:0] PTR_REM_LO = 8'h10;
   localparam logic [7:0] PTR_LOC_LO = 8'h15;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int CFG_SUPPRESS = 7;
   localparam int CFG_SHUTDOWN = 6;
   localparam int CFG_PIN_FUNC = 5;
   localparam int CFG_RANGE = 2;
   localparam logic [7:0] CFG_MASK = 8'he4;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [3:0] RATE_RST = 4'h8;
   localparam logic [3:0] RATE_MAX = 4'h9;
   localparam logic [7:0] RES_RST = 8'h00;
   localparam int CH_LOC = 0;
   localparam int CH_REM = 1;

   // ------------------------------------------------------------
   // Timing and number formats
   // ------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int SLOW_PERIOD_S = 16;
   localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_S * CLK_HZ;
   localparam logic signed [13:0] EXT_OFFSET = 14'sh0400;
   localparam logic signed [13:0] STD_MIN = -14'sd640;
   localparam logic signed [13:0] STD_MAX = 14'sh07ff;
   localparam logic signed [13:0] EXT_MAX = 14'sh0fff;

   typedef enum logic {SEQ_IDLE = 1'b0, SEQ_CONV = 1'b1} tmr_seq_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] ptr;
      logic [7:0] wdata;
   } tmr_acc_s;

   typedef struct packed {
      logic done;
      logic [12:0] temp;
   } tmr_conv_s;

   typedef struct packed {
      logic [11:0] high;
      logic [11:0] low;
      logic [11:0] crit;
   } tmr_lim_s;

   typedef struct packed {
      logic o;
      logic oe_n;
   } tmr_od_s;

endpackage

// *** src/tmr_result_pair.sv ***
/*
 * One 12-bit result held as an upper byte and a fraction byte, with the read lock.
 * Assumes read strobes are one-cycle pulses from the pointer logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tmr_result_pair (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic upd_i,
   input wire logic [11:0] val_i,
   input wire logic rd_hi_i,
   input wire logic rd_lo_i,
   input wire logic rd_other_i,
   output logic [7:0] hi_o,
   output logic [7:0] lo_o
);
   import tmr_pkg::*;

   logic lock_hi_r, lock_lo_r;
   logic lock_hi_nxt, lock_lo_nxt;
   logic [7:0] hi_r, lo_r;

   // Reading one half locks the other; reading the locked half closes the pair
   assign lock_hi_nxt = rd_other_i ? 1'b0 : rd_lo_i ? !lock_lo_r : rd_hi_i ? 1'b0 : lock_hi_r;
   assign lock_lo_nxt = rd_other_i ? 1'b0 : rd_hi_i ? !lock_hi_r : rd_lo_i ? 1'b0 : lock_lo_r;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lock_hi_r <= 1'b0;
         lock_lo_r <= 1'b0;
         hi_r <= RES_RST;
         lo_r <= RES_RST;
      end
      else
      begin
         lock_hi_r <= lock_hi_nxt;
         lock_lo_r <= lock_lo_nxt;
         // Gate on the next lock so an update in the reading cycle cannot split the pair
         if (upd_i && !lock_hi_nxt)
            hi_r <= val_i[11:4];
         if (upd_i && !lock_lo_nxt)
            lo_r <= {val_i[3:0], 4'h0};
      end
   end

   assign hi_o = hi_r;
   assign lo_o = lo_r;

   lock_holds_lo_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_hi_i && !rd_lo_i && !rd_other_i && !lock_hi_r)
      ##1 (!rd_hi_i && !rd_lo_i && !rd_other_i) |=> $stable(lo_r))
      else $error("fraction byte changed while locked");

   reset_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> (hi_r == 8'h00 && lo_r == 8'h00))
      else $error("result bytes not zero after reset");

   frac_nibble_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      lo_r[3:0] == 4'h0)
      else $error("fraction low nibble not zero");

endmodule // tmr_result_pair

`default_nettype wire
